// ---- pkg/mfid_cfg.svh ----
// constants of the multi-function input decoder
// included by the package and by the decoder module
`ifndef MFID_CFG_SVH
`define MFID_CFG_SVH
// register byte offsets
`define MFID_OFS_FUNC      7'h00
`define MFID_OFS_MODE      7'h04
`define MFID_OFS_STATUS    7'h08
`define MFID_OFS_JOG       7'h0C
`define MFID_OFS_CTRL      7'h10
`define MFID_PRESET_BIT    6
// function select field layout, 5 bits per terminal
`define MFID_FN_W          5
// mode register fields
`define MFID_MODE_INIT_LSB 0
`define MFID_MODE_FSRC_BIT 4
`define MFID_MODE_STOP_LSB 5
`define MFID_MODE_AFN_LSB  8
`define MFID_MODE_PID_BIT  12
// reset values
`define MFID_RST_FUNC      25'h0A418A2
`define MFID_RST_MODE      13'h0000
`define MFID_RST_FREQ      16'h0000
// function codes of the input terminals
`define MFID_FN_3WIRE      5'h00
`define MFID_FN_2W_STOP    5'h01
`define MFID_FN_STEP1      5'h02
`define MFID_FN_STEP2      5'h03
`define MFID_FN_STEP3      5'h04
`define MFID_FN_STEP4      5'h05
`define MFID_FN_JOG_SEL    5'h06
`define MFID_FN_BB_A       5'h08
`define MFID_FN_BB_B       5'h09
`define MFID_FN_HOLD       5'h0A
`define MFID_FN_OVERHEAT   5'h0B
`define MFID_FN_FORWARD_JOG_INPUT       5'h0C
`define MFID_FN_REVERSE_JOG_INPUT       5'h0D
`define MFID_FN_PID_RST    5'h0E
`define MFID_FN_PID_OFF    5'h0F
`define MFID_FN_EXT_A      5'h10
`define MFID_FN_EXT_B      5'h11
`define MFID_FN_SEARCH1    5'h15
`define MFID_FN_SEARCH2    5'h16
// 3-wire initialisation modes
`define MFID_INIT_3W_A     4'h8
`define MFID_INIT_3W_B     4'hA
`define MFID_INIT_3W_C     4'hC
// timing
`define MFID_CLK_MHZ       100
`define MFID_JOG_CONFL_MS  500
`endif

// ---- pkg/mfid_pkg.sv ----
// types of the multi-function input decoder
// constants live in mfid_cfg.svh
`include "mfid_cfg.svh"
package mfid_pkg;
	typedef enum logic [1:0] {
		RM_2WIRE,
		RM_2WIRE_LATCH,
		RM_3WIRE
	} mfid_run_mode_t;
	typedef enum logic [1:0] {
		RS_STOP,
		RS_FWD,
		RS_REV
	} mfid_run_state_t;
	typedef logic [15:0] mfid_freq_t;
endpackage

// ---- logic/mfid_top.sv ----
// multi-function input decoder: terminals to drive control actions
// assumes terminal levels synchronous to ref_clk, 1 = contact closed
//
// Summary of operation
// - selectors 5..8 must strictly increase
// - both speed search codes flag error
// - init 8/10/12 plus code 00: 3-wire
// - plain 2-wire: fwd, rev, or stop
// - code 01 on terminal 5 latches 2-wire
// - other codes: non-latching 2-wire
// - fwd and rev both on in 2-wire modes: error, stop
// - codes 02-06 select speed and jog
// - step bits form binary index, bit1 lsb
// - step 1 preset or analog by source
// - step 2 aux input when analog select 0
// - baseblock while running blocks, then resumes
// - baseblock in deceleration: coast, stay stopped
// - ramp hold freezes output frequency
// - run off during hold: coast, store
// - overheat input raises self-clearing alarm
// - jog inputs run at jog frequency
// - jog overrides every other reference
// - both jogs over 500 ms: stop
// - integral reset input clears integrator
// - pid disable input gives open loop
// - external fault latches terminal, coasts
`timescale 1ns/10ps
`default_nettype none
`include "mfid_cfg.svh"
module mfid_top #(
	parameter int FW           = 16,
	parameter int JOG_CONFL_CY =
		`MFID_JOG_CONFL_MS * 1000 * `MFID_CLK_MHZ
) (
	input  wire logic             ref_clk,
	input  wire logic             arst_n,
	input  wire logic [6:0]       avs_address,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic [31:0]      avs_writedata,
	input  wire logic [3:0]       avs_byteenable,
	output logic [31:0]           avs_readdata,
	output logic                  avs_waitrequest,
	input  wire logic             forward_switch,
	input  wire logic             reverse_switch,
	input  wire logic             terminal3_input,
	input  wire logic [3:0]       multi_input,
	input  wire logic             decel_active,
	input  wire mfid_pkg::mfid_freq_t out_freq,
	input  wire mfid_pkg::mfid_freq_t voltage_analog_input,
	input  wire mfid_pkg::mfid_freq_t current_analog_input,
	input  wire mfid_pkg::mfid_freq_t aux_analog_input,
	output logic                  run_fwd,
	output logic                  run_rev,
	output mfid_pkg::mfid_freq_t  freq_ref,
	output logic                  output_block,
	output logic                  coast_stop,
	output logic                  zero_freq,
	output logic                  ramp_hold,
	output mfid_pkg::mfid_freq_t  held_freq,
	output logic                  stop_request,
	output logic [1:0]            stop_method,
	output logic                  setting_error,
	output logic                  freq_cmd_error,
	output logic                  baseblock_alarm,
	output logic                  overheat_alarm,
	output logic                  ext_fault,
	output logic [3:0]            ext_fault_terminal,
	output logic                  pid_integ_reset,
	output logic                  pid_open_loop
);
	import mfid_pkg::*;

	localparam int CW = $clog2(JOG_CONFL_CY + 1);

	// one hit per terminal whose selector equals code; B inverts
	function automatic logic fn_on(input logic [24:0] sel,
			input logic [4:0] lvl, input logic [4:0] code,
			input logic inv);
		logic r;
		r = 1'b0;
		for (int i = 0; i < 5; i++) begin
			if (sel[i*5 +: 5] == code)
				r = r | (lvl[i] ^ inv);
		end
		return r;
	endfunction

	function automatic logic fn_used(input logic [24:0] sel,
			input logic [4:0] code);
		logic r;
		r = 1'b0;
		for (int i = 0; i < 5; i++) begin
			if (sel[i*5 +: 5] == code)
				r = 1'b1;
		end
		return r;
	endfunction

	function automatic logic [31:0] be_merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		end
		return r;
	endfunction

	// reset release through two flops
	logic [1:0] rst_sync_q;
	wire        rst_n = rst_sync_q[1];
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end

	// software registers
	logic [24:0]     func_sel_q;
	logic [12:0]     mode_q;
	mfid_freq_t      jog_freq_q;
	mfid_freq_t      preset_q [16];
	logic            wait_q;
	logic [31:0]     rdata_q;

	wire       req       = avs_read | avs_write;
	wire       wr_go     = avs_write & ~wait_q;
	wire       hit_func  = avs_address == `MFID_OFS_FUNC;
	wire       hit_mode  = avs_address == `MFID_OFS_MODE;
	wire       hit_stat  = avs_address == `MFID_OFS_STATUS;
	wire       hit_jog   = avs_address == `MFID_OFS_JOG;
	wire       hit_ctrl  = avs_address == `MFID_OFS_CTRL;
	wire       hit_pre   = avs_address[`MFID_PRESET_BIT] &
		(avs_address[1:0] == 2'b00);
	wire [3:0] pre_idx   = avs_address[5:2];
	wire       fault_clr = wr_go & hit_ctrl & avs_byteenable[0] &
		avs_writedata[0];

	wire [3:0] init_mode  = mode_q[`MFID_MODE_INIT_LSB +: 4];
	wire       freq_src   = mode_q[`MFID_MODE_FSRC_BIT];
	wire [1:0] stop_sel   = mode_q[`MFID_MODE_STOP_LSB +: 2];
	wire [3:0] analog_fn  = mode_q[`MFID_MODE_AFN_LSB +: 4];
	wire       pid_enable = mode_q[`MFID_MODE_PID_BIT];

	logic [31:0] status_w;
	wire [31:0]  rd_mux =
		hit_func ? {7'h00, func_sel_q} :
		hit_mode ? {19'h00000, mode_q} :
		hit_stat ? status_w :
		hit_jog  ? {16'h0000, jog_freq_q} :
		hit_pre  ? {16'h0000, preset_q[pre_idx]} : 32'h00000000;

	// answer one cycle after a request appears
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h00000000;
		end else begin
			wait_q <= ~(req & wait_q);
			if (avs_read & wait_q)
				rdata_q <= rd_mux;
		end
	end

	logic [31:0] mrg_func, mrg_mode, mrg_jog, mrg_pre;
	assign mrg_func = be_merge({7'h00, func_sel_q}, avs_writedata,
		avs_byteenable);
	assign mrg_mode = be_merge({19'h00000, mode_q}, avs_writedata,
		avs_byteenable);
	assign mrg_jog  = be_merge({16'h0000, jog_freq_q}, avs_writedata,
		avs_byteenable);
	assign mrg_pre  = be_merge({16'h0000, preset_q[pre_idx]},
		avs_writedata, avs_byteenable);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			func_sel_q <= `MFID_RST_FUNC;
			mode_q     <= `MFID_RST_MODE;
			jog_freq_q <= `MFID_RST_FREQ;
			for (int k = 0; k < 16; k++)
				preset_q[k] <= `MFID_RST_FREQ;
		end else if (wr_go) begin
			if (hit_func)
				func_sel_q <= mrg_func[24:0];
			if (hit_mode)
				mode_q <= mrg_mode[12:0];
			if (hit_jog)
				jog_freq_q <= mrg_jog[15:0];
			if (hit_pre)
				preset_q[pre_idx] <= mrg_pre[15:0];
		end
	end

	// terminal order: 3, 5, 6, 7, 8
	wire [4:0] lvl = {multi_input, terminal3_input};
	wire [4:0] sel5 = func_sel_q[5 +: 5];
	wire [4:0] sel6 = func_sel_q[10 +: 5];
	wire [4:0] sel7 = func_sel_q[15 +: 5];
	wire [4:0] sel8 = func_sel_q[20 +: 5];

	wire order_bad = ~((sel5 < sel6) & (sel6 < sel7) & (sel7 < sel8));
	wire search_bad = fn_used(func_sel_q, `MFID_FN_SEARCH1) &
		fn_used(func_sel_q, `MFID_FN_SEARCH2);

	wire init_3w = (init_mode == `MFID_INIT_3W_A) |
		(init_mode == `MFID_INIT_3W_B) |
		(init_mode == `MFID_INIT_3W_C);
	wire mode_3w = init_3w & fn_used(func_sel_q, `MFID_FN_3WIRE);
	wire mode_lat = ~mode_3w & (sel5 == `MFID_FN_2W_STOP);
	wire mfid_run_mode_t run_mode = mode_3w ? RM_3WIRE :
		mode_lat ? RM_2WIRE_LATCH : RM_2WIRE;

	wire bb_in   = fn_on(func_sel_q, lvl, `MFID_FN_BB_A, 1'b0) |
		fn_on(func_sel_q, lvl, `MFID_FN_BB_B, 1'b1);
	wire ext_in  = fn_on(func_sel_q, lvl, `MFID_FN_EXT_A, 1'b0) |
		fn_on(func_sel_q, lvl, `MFID_FN_EXT_B, 1'b1);
	wire hold_in = fn_on(func_sel_q, lvl, `MFID_FN_HOLD, 1'b0);
	wire oh_in   = fn_on(func_sel_q, lvl, `MFID_FN_OVERHEAT, 1'b0);
	wire forward_jog_input_in = fn_on(func_sel_q, lvl, `MFID_FN_FORWARD_JOG_INPUT, 1'b0);
	wire reverse_jog_input_in = fn_on(func_sel_q, lvl, `MFID_FN_REVERSE_JOG_INPUT, 1'b0);
	wire pidr_in = fn_on(func_sel_q, lvl, `MFID_FN_PID_RST, 1'b0);
	wire pido_in = fn_on(func_sel_q, lvl, `MFID_FN_PID_OFF, 1'b0);
	wire jsel_in = fn_on(func_sel_q, lvl, `MFID_FN_JOG_SEL, 1'b0);
	wire [3:0] step_idx = {
		fn_on(func_sel_q, lvl, `MFID_FN_STEP4, 1'b0),
		fn_on(func_sel_q, lvl, `MFID_FN_STEP3, 1'b0),
		fn_on(func_sel_q, lvl, `MFID_FN_STEP2, 1'b0),
		fn_on(func_sel_q, lvl, `MFID_FN_STEP1, 1'b0)};

	// latched run state for 3-wire and latching 2-wire
	mfid_run_state_t rs_q, rs_d;
	wire t5 = multi_input[0];
	always_comb begin
		rs_d = rs_q;
		case (run_mode)
			// reverse switch is the normally closed stop
			RM_3WIRE: begin
				if (!reverse_switch)
					rs_d = RS_STOP;
				else if (forward_switch || rs_q != RS_STOP)
					rs_d = t5 ? RS_REV : RS_FWD;
			end
			RM_2WIRE_LATCH: begin
				if (t5 || (forward_switch && reverse_switch))
					rs_d = RS_STOP;
				else if (forward_switch)
					rs_d = RS_FWD;
				else if (reverse_switch)
					rs_d = RS_REV;
			end
			default: rs_d = RS_STOP;
		endcase
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			rs_q <= RS_STOP;
		else
			rs_q <= rs_d;
	end

	wire both_on  = forward_switch & reverse_switch;
	wire cmd_err  = (run_mode != RM_3WIRE) & both_on;
	wire w2_fwd   = forward_switch & ~reverse_switch;
	wire w2_rev   = reverse_switch & ~forward_switch;
	wire base_fwd = (run_mode == RM_2WIRE) ? w2_fwd : rs_q == RS_FWD;
	wire base_rev = (run_mode == RM_2WIRE) ? w2_rev : rs_q == RS_REV;

	// jog conflict timer
	logic [CW-1:0] jog_cnt_q;
	logic          jog_to_q;
	logic          jog_rev_q;
	wire           jog_both = forward_jog_input_in & reverse_jog_input_in;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			jog_cnt_q <= '0;
			jog_to_q  <= 1'b0;
			jog_rev_q <= 1'b0;
		end else begin
			if (!jog_both) begin
				jog_cnt_q <= '0;
				jog_to_q  <= 1'b0;
			end else if (jog_cnt_q == CW'(JOG_CONFL_CY)) begin
				jog_to_q <= 1'b1;
			end else begin
				jog_cnt_q <= jog_cnt_q + CW'(1);
			end
			// direction held while both are pressed
			if (forward_jog_input_in ^ reverse_jog_input_in)
				jog_rev_q <= reverse_jog_input_in;
		end
	end
	wire jog_run = (forward_jog_input_in | reverse_jog_input_in) & ~jog_to_q;
	wire jog_dir = (forward_jog_input_in ^ reverse_jog_input_in) ? reverse_jog_input_in : jog_rev_q;
	wire cmd_fwd = jog_run ? ~jog_dir : base_fwd & ~cmd_err;
	wire cmd_rev = jog_run ? jog_dir : base_rev & ~cmd_err;
	wire run_cmd = cmd_fwd | cmd_rev;

	// baseblock, hold release and fault state
	logic       bb_stop_q;
	logic       hold_rel_q;
	logic       fault_q;
	logic [3:0] fault_term_q;
	mfid_freq_t held_q;
	wire        fault_any = fault_q | ext_in;
	wire [3:0]  term_num =
		fn_on(func_sel_q, 5'b00001 & lvl, `MFID_FN_EXT_A, 1'b0) |
		fn_on(func_sel_q, 5'b00001 & ~lvl, `MFID_FN_EXT_B, 1'b0) ?
			4'h3 :
		fn_on(func_sel_q, 5'b00010 & lvl, `MFID_FN_EXT_A, 1'b0) |
		fn_on(func_sel_q, 5'b00010 & ~lvl, `MFID_FN_EXT_B, 1'b0) ?
			4'h5 :
		fn_on(func_sel_q, 5'b00100 & lvl, `MFID_FN_EXT_A, 1'b0) |
		fn_on(func_sel_q, 5'b00100 & ~lvl, `MFID_FN_EXT_B, 1'b0) ?
			4'h6 :
		fn_on(func_sel_q, 5'b01000 & lvl, `MFID_FN_EXT_A, 1'b0) |
		fn_on(func_sel_q, 5'b01000 & ~lvl, `MFID_FN_EXT_B, 1'b0) ?
			4'h7 : 4'h8;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bb_stop_q    <= 1'b0;
			hold_rel_q   <= 1'b0;
			fault_q      <= 1'b0;
			fault_term_q <= 4'h0;
			held_q       <= `MFID_RST_FREQ;
		end else begin
			// stay stopped after baseblock in decel
			if (bb_in && decel_active)
				bb_stop_q <= 1'b1;
			else if (!run_cmd)
				bb_stop_q <= 1'b0;
			if (hold_in && !run_cmd && !hold_rel_q) begin
				hold_rel_q <= 1'b1;
				held_q     <= out_freq;
			end else if (!hold_in) begin
				hold_rel_q <= 1'b0;
			end
			// fault latch, new fault beats clear
			if (ext_in && !fault_q) begin
				fault_q      <= 1'b1;
				fault_term_q <= term_num;
			end else if (fault_clr && !ext_in) begin
				fault_q <= 1'b0;
			end
		end
	end

	// reference selection
	wire [16:0] an_sum = {1'b0, voltage_analog_input} +
		{1'b0, current_analog_input};
	wire mfid_freq_t an_ref = an_sum[16] ? 16'hFFFF : an_sum[15:0];
	wire mfid_freq_t step1 = freq_src ? an_ref : preset_q[0];
	wire mfid_freq_t step2 = (analog_fn == 4'h0) ?
		aux_analog_input : preset_q[1];
	wire mfid_freq_t step_ref = (step_idx == 4'h0) ? step1 :
		(step_idx == 4'h1) ? step2 : preset_q[step_idx];
	wire mfid_freq_t ref_sel = (jog_run | jsel_in) ?
		jog_freq_q : step_ref;

	// baseblock blocks output, resumes on clear unless it came during decel (then held until run is removed)
	wire block_now = bb_in | bb_stop_q | fault_any | jog_to_q |
		hold_rel_q;
	wire coast_now = fault_any | hold_rel_q | bb_stop_q |
		(bb_in & decel_active);
	wire set_err   = order_bad | search_bad;

	assign status_w = {18'h00000, fault_term_q, pid_open_loop,
		jog_to_q, ramp_hold, fault_q, oh_in, bb_in, cmd_err,
		set_err, run_rev, run_fwd};

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_fwd         <= 1'b0;
			run_rev         <= 1'b0;
			freq_ref        <= `MFID_RST_FREQ;
			output_block    <= 1'b0;
			coast_stop      <= 1'b0;
			zero_freq       <= 1'b0;
			ramp_hold       <= 1'b0;
			stop_request    <= 1'b0;
			setting_error   <= 1'b0;
			freq_cmd_error  <= 1'b0;
			baseblock_alarm <= 1'b0;
			overheat_alarm  <= 1'b0;
			pid_integ_reset <= 1'b0;
			pid_open_loop   <= 1'b0;
		end else begin
			run_fwd         <= cmd_fwd & ~block_now;
			run_rev         <= cmd_rev & ~block_now;
			freq_ref        <= ref_sel;
			output_block    <= block_now;
			coast_stop      <= coast_now;
			zero_freq       <= bb_stop_q | (bb_in & decel_active);
			ramp_hold       <= hold_in & ~hold_rel_q;
			stop_request    <= jog_to_q;
			setting_error   <= set_err;
			freq_cmd_error  <= cmd_err;
			baseblock_alarm <= bb_in;
			overheat_alarm  <= oh_in;
			pid_integ_reset <= pidr_in;
			pid_open_loop   <= pido_in | ~pid_enable;
		end
	end

	assign avs_readdata       = rdata_q;
	assign avs_waitrequest    = wait_q;
	assign held_freq          = held_q;
	assign ext_fault          = fault_q;
	assign ext_fault_terminal = fault_term_q;
	assign stop_method        = stop_sel;
endmodule
`default_nettype wire

// ---- tb/mfid_switches.sv ----
// contact model in front of the decoder's seven terminals
// assumes want comes from the bench on ref_clk; 1 = contact closed
`timescale 1ns/10ps
`default_nettype none
module mfid_switches (
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	input  wire logic [6:0] want,
	input  wire logic [2:0] lag,
	output logic      [6:0] pins
);
	logic [2:0] cnt_q;
	// slow contacts: moving bits switch together lag+1 cycles after want changes
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pins <= 7'h00;
			cnt_q <= 3'h0;
		end else if (want == pins) begin
			cnt_q <= 3'h0;
		end else if (cnt_q >= lag) begin
			pins <= want;
			cnt_q <= 3'h0;
		end else begin
			cnt_q <= cnt_q + 3'h1;
		end
	end
endmodule
`default_nettype wire

// ---- tb/mfid_monitor.sv ----
// assertions on the decoder's bus handshake and control outputs
// assumes it is bound into mfid_top, everything on ref_clk
`timescale 1ns/10ps
`default_nettype none
module mfid_monitor (
	input wire logic       ref_clk,
	input wire logic       arst_n,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest,
	input wire logic       run_fwd,
	input wire logic       run_rev,
	input wire logic       output_block,
	input wire logic       coast_stop,
	input wire logic       zero_freq,
	input wire logic       stop_request,
	input wire logic       freq_cmd_error,
	input wire logic       baseblock_alarm,
	input wire logic       ext_fault,
	input wire logic [3:0] ext_fault_terminal
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);
	chk_bus_one_wait:
	assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("bus answer late");
	chk_bus_wait_back:
	assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("wait low too long");
	chk_dir_exclusive:
	assert property (!(run_fwd && run_rev)) else $error("both directions");
	chk_conflict_stops:
	assert property (freq_cmd_error [*2] |-> !run_fwd && !run_rev)
		else $error("runs during conflict");
	chk_jog_halt:
	assert property (stop_request |-> !(run_fwd || run_rev))
		else $error("runs after jog conflict");
	chk_bb_blocks:
	assert property (baseblock_alarm |-> output_block)
		else $error("baseblock without block");
	chk_coast_zero:
	assert property (zero_freq |-> output_block && coast_stop)
		else $error("zero freq without coast");
	chk_fault_sticks:
	assert property (ext_fault && !avs_write |=> ext_fault)
		else $error("fault dropped alone");
	chk_fault_site:
	assert property (ext_fault |->
		ext_fault_terminal inside {4'h3, 4'h5, 4'h6, 4'h7, 4'h8})
		else $error("bad fault terminal");
	chk_fault_blocks:
	assert property (ext_fault |-> output_block && coast_stop)
		else $error("fault without block");
	cov_fault: cover property (ext_fault);
	cov_jog_stop: cover property (stop_request);
	cov_bb_decel: cover property (zero_freq);
	cov_conflict: cover property (freq_cmd_error);
endmodule
bind mfid_top mfid_monitor mon (.ref_clk, .arst_n, .avs_read, .avs_write,
	.avs_waitrequest, .run_fwd, .run_rev, .output_block, .coast_stop,
	.zero_freq, .stop_request, .freq_cmd_error, .baseblock_alarm,
	.ext_fault, .ext_fault_terminal);
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the multi-function input decoder
// assumes design, contact model and monitor are compiled before it
`timescale 1ns/10ps
`default_nettype none
module tb;
	import mfid_pkg::*;
	typedef struct packed {logic [6:0] w; logic [2:0] fre;} mfid_row_t;
	logic        ref_clk, arst_n, avs_read, avs_write, avs_waitrequest;
	logic [6:0]  avs_address, want, pins;
	logic [31:0] avs_writedata, avs_readdata, rd, fv [4];
	logic [3:0]  avs_byteenable, multi_input, ext_fault_terminal;
	logic        forward_switch, reverse_switch, terminal3_input;
	logic        decel_active, run_fwd, run_rev, output_block, coast_stop;
	logic        zero_freq, ramp_hold, stop_request, setting_error;
	logic        freq_cmd_error, baseblock_alarm, overheat_alarm, ext_fault;
	logic        pid_integ_reset, pid_open_loop;
	logic [1:0]  stop_method;
	logic [2:0]  lag;
	mfid_freq_t  out_freq, voltage_analog_input, current_analog_input;
	mfid_freq_t  aux_analog_input, freq_ref, held_freq;
	int          n_mismatch, checks_done;
	mfid_row_t   rows [8];
	// short jog conflict limit keeps the run brief
	mfid_top #(.JOG_CONFL_CY(20)) dut (.ref_clk, .arst_n, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest, .forward_switch, .reverse_switch,
		.terminal3_input, .multi_input, .decel_active, .out_freq,
		.voltage_analog_input, .current_analog_input, .aux_analog_input,
		.run_fwd, .run_rev, .freq_ref, .output_block, .coast_stop,
		.zero_freq, .ramp_hold, .held_freq, .stop_request, .stop_method,
		.setting_error, .freq_cmd_error, .baseblock_alarm, .overheat_alarm,
		.ext_fault, .ext_fault_terminal, .pid_integ_reset, .pid_open_loop);
	mfid_switches sw (.ref_clk, .arst_n, .want, .lag, .pins);
	assign {multi_input, terminal3_input} = pins[6:2];
	assign {reverse_switch, forward_switch} = pins[1:0];
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// the whole sequence needs about 1200 cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		conclude();
	end
	function automatic logic [31:0] fn(logic [4:0] a, b, c, d, e);
		return {7'h00, e, d, c, b, a};
	endfunction
	function automatic logic [15:0] pv(int i);
		return 16'(16'h0111 * i + 16'h0005);
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	// no local limit: a stuck slave is left to the watchdog
	task automatic bus(input logic wr, input logic [6:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic set(input logic [6:0] w);
		@(posedge ref_clk);
		want <= w;
		repeat (12) @(posedge ref_clk);
	endtask
	task automatic done(input string s);
		$display("test %s finished, %0d mismatches", s, n_mismatch);
	endtask
	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		{avs_read, avs_write, decel_active, arst_n} = 4'h0;
		avs_address = 7'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		want = 7'h00;
		lag = 3'h5;
		out_freq = 16'h0000;
		voltage_analog_input = 16'h0100;
		current_analog_input = 16'h0020;
		aux_analog_input = 16'h0ABC;
		n_mismatch = 0;
		checks_done = 0;
		rows = '{'{7'h01, 3'h4}, '{7'h0A, 3'h2}, '{7'h78, 3'h0},
			'{7'h2B, 3'h1}, '{7'h51, 3'h4}, '{7'h32, 3'h2},
			'{7'h49, 3'h4}, '{7'h1B, 3'h1}};
		fv = '{fn(5'h02, 5'h03, 5'h02, 5'h04, 5'h05),
			fn(5'h02, 5'h03, 5'h03, 5'h04, 5'h05),
			fn(5'h15, 5'h02, 5'h03, 5'h04, 5'h16),
			fn(5'h15, 5'h02, 5'h03, 5'h04, 5'h05)};
		repeat (5) @(posedge ref_clk);
		chk({avs_waitrequest, run_fwd}, 2'h2);
		repeat (5) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		bus(1'b0, 7'h00, 32'h0);
		chk(rd, 32'h00A418A2);
		// only lane 1 enabled: low byte must keep its reset value
		avs_byteenable <= 4'h2;
		bus(1'b1, 7'h0C, 32'h000055AA);
		avs_byteenable <= 4'hF;
		bus(1'b0, 7'h0C, 32'h0);
		chk(rd, 32'h00005500);
		bus(1'b1, 7'h0C, 32'h0777);
		bus(1'b0, 7'h0C, 32'h0);
		chk(rd, 32'h0777);
		// status is read-only: write must not land
		bus(1'b1, 7'h08, 32'hFFFF);
		bus(1'b0, 7'h08, 32'h0);
		chk(rd, 32'h0200);
		bus(1'b1, 7'h20, 32'h1234);
		bus(1'b0, 7'h20, 32'h0);
		chk(rd, 32'h0);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 7'h00, fv[i]);
			set(want);
			chk(setting_error, i != 3);
		end
		done("registers");
		bus(1'b1, 7'h04, 32'h100);
		for (int i = 0; i < 16; i++) bus(1'b1, 7'(7'h40 + 4 * i), pv(i));
		foreach (rows[i]) begin
			set(rows[i].w);
			chk({run_fwd, run_rev, freq_cmd_error}, rows[i].fre);
		end
		lag <= 3'h0;
		for (int i = 0; i < 16; i++) begin
			set(7'(i << 3));
			chk(freq_ref, pv(i));
		end
		bus(1'b1, 7'h04, 32'h110);
		set(7'h00);
		chk(freq_ref, 16'h0120);
		bus(1'b1, 7'h04, 32'h010);
		set(7'h08);
		chk(freq_ref, 16'h0ABC);
		done("speed select");
		bus(1'b1, 7'h00, fn(5'h06, 5'h00, 5'h02, 5'h03, 5'h04));
		for (int i = 8; i <= 12; i += 2) begin
			bus(1'b1, 7'h04, {24'h000001, 4'h0, 4'(i)});
			set(7'h02);
			set(7'h03);
			set(7'h02);
			chk({run_fwd, run_rev}, 2'h2);
			set(7'h0A);
			chk({run_fwd, run_rev}, 2'h1);
			set(7'h08);
			chk({run_fwd, run_rev}, 2'h0);
		end
		bus(1'b1, 7'h04, 32'h100);
		bus(1'b1, 7'h00, fn(5'h06, 5'h01, 5'h02, 5'h03, 5'h04));
		set(7'h01);
		set(7'h00);
		chk({run_fwd, run_rev}, 2'h2);
		set(7'h08);
		chk({run_fwd, run_rev}, 2'h0);
		set(7'h02);
		set(7'h00);
		chk({run_fwd, run_rev}, 2'h1);
		done("run modes");
		bus(1'b1, 7'h00, fn(5'h06, 5'h02, 5'h08, 5'h0B, 5'h10));
		set(7'h01);
		set(7'h11);
		chk({baseblock_alarm, output_block}, 2'h3);
		set(7'h01);
		chk({baseblock_alarm, output_block, run_fwd}, 3'h1);
		decel_active <= 1'b1;
		set(7'h11);
		chk({zero_freq, coast_stop, output_block}, 3'h7);
		set(7'h01);
		chk(run_fwd, 1'b0);
		decel_active <= 1'b0;
		set(7'h00);
		set(7'h21);
		chk({overheat_alarm, run_fwd}, 2'h3);
		set(7'h01);
		chk(overheat_alarm, 1'b0);
		set(7'h41);
		chk({ext_fault, ext_fault_terminal, coast_stop}, 6'h31);
		set(7'h01);
		chk({ext_fault, output_block}, 2'h3);
		bus(1'b1, 7'h10, 32'h1);
		set(7'h00);
		chk(ext_fault, 1'b0);
		bus(1'b1, 7'h00, fn(5'h06, 5'h02, 5'h09, 5'h0B, 5'h10));
		set(7'h10);
		chk(baseblock_alarm, 1'b0);
		set(7'h00);
		chk(baseblock_alarm, 1'b1);
		done("protection");
		bus(1'b1, 7'h00, fn(5'h0F, 5'h0A, 5'h0C, 5'h0D, 5'h0E));
		bus(1'b1, 7'h04, 32'h1140);
		out_freq <= 16'h1234;
		set(7'h01);
		set(7'h09);
		chk(ramp_hold, 1'b1);
		set(7'h08);
		chk({held_freq, coast_stop, ramp_hold}, 18'h048D2);
		set(7'h10);
		chk({run_fwd, run_rev, freq_ref}, 18'h20777);
		set(7'h20);
		chk({run_fwd, run_rev, freq_ref}, 18'h10777);
		set(7'h30);
		chk(stop_request, 1'b0);
		repeat (20) @(posedge ref_clk);
		chk({stop_request, stop_method, run_rev}, 4'hC);
		set(7'h40);
		chk(pid_integ_reset, 1'b1);
		set(7'h04);
		chk(pid_open_loop, 1'b1);
		set(7'h00);
		chk({pid_open_loop, pid_integ_reset}, 2'h0);
		done("hold jog pid");
		set(7'h10);
		arst_n <= 1'b0;
		@(posedge ref_clk);
		chk({run_fwd, avs_waitrequest}, 2'h1);
		arst_n <= 1'b1;
		// internal reset lasts two edges after release
		repeat (3) @(posedge ref_clk);
		chk({run_fwd, ext_fault, avs_waitrequest}, 3'h1);
		bus(1'b0, 7'h00, 32'h0);
		chk(rd, 32'h00A418A2);
		done("mid-run reset");
		conclude();
	end
endmodule
`default_nettype wire
